//--- inc/synth_event_pkg.sv
// Purpose: Shared constants for the synthesizer event sticky status bank.
// Assumes: AXI4-Lite with 32-bit data, one register per aligned word.
// Notes: Register indexes are word indexes; the byte address is four times the index.
package synth_event_pkg;

   // Bus geometry.
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int IDX_W = 10;
   localparam int REG_W = 8;

   // Register indexes.
   localparam logic [9:0] IDX_STEP_LO = 10'h1ac;
   localparam logic [9:0] IDX_STEP_HI = 10'h1ad;
   localparam logic [9:0] IDX_MON0 = 10'h1b0;
   localparam logic [9:0] IDX_MASK_LO = 10'h1b8;
   localparam logic [9:0] IDX_MASK_HI = 10'h1b9;
   localparam logic [9:0] IDX_MASK_MON = 10'h1ba;
   localparam logic [9:0] IDX_CFG = 10'h1bc;

   // Implemented bits of each status layout; all other bits are reserved and read zero.
   localparam logic [7:0] STEP_LO_VALID = 8'hf3;
   localparam logic [7:0] STEP_HI_VALID = 8'h3f;
   localparam logic [7:0] MON_VALID_NARROW = 8'h34;
   localparam logic [7:0] MON_VALID_WIDE = 8'hf4;
   localparam logic [7:0] CFG_VALID = 8'h01;

   // Field positions.
   localparam int CFG_WIDE_BIT = 0;
   localparam int MON_UNLOCK_BIT = 2;

   // Reset values.
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic CFG_WIDE_RESET = 1'b0;

   // AXI responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- core/sticky_bank.sv
// Purpose: One 8-bit bank of sticky event bits, cleared by writing one.
// Assumes: Set and clear inputs are on mclk; events are pulses or levels.
// Notes: Bits outside validBits are held at zero.
`timescale 1ns/1ps
module sticky_bank (
   // Clock and reset.
   input wire logic mclk,
   input wire logic srst,
   // Events and acknowledges.
   input wire logic [7:0] setEvents,
   input wire logic [7:0] clearBits,
   input wire logic [7:0] validBits,
   // Current state.
   output logic [7:0] status
);

   typedef struct packed {
      logic [7:0] bits;
   } bank_type;

   bank_type s_q;
   bank_type s_d;

   // A set in the same cycle as a clear wins, so no event is lost.
   always_comb begin
      s_d = s_q;
      s_d.bits = ((s_q.bits & ~clearBits) | setEvents) & validBits;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s_q.bits <= synth_event_pkg::STATUS_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign status = s_q.bits;

endmodule

//--- core/synth_event_sticky_status.sv
// Purpose: Sticky status bank for synthesizer phase-step, alignment and lock events.
// Assumes: Event inputs come from logic clocked by mclk.
// Notes: Registers are reached over AXI4-Lite; irq is a level.
// Contract
// - Low step bits 7..4: pll1 dividers D..A.
// - Low step bits 1,0: pll0 B,A; 3,2 reserved.
// - High step bits 5,4: pll3 B,A; 7,6 reserved.
// - High step bits 3..0: pll2 dividers D..A.
// - Step bit set from completion until acknowledged.
// - Monitor bit 4: divider A alignment, held.
// - Monitor bit 5: divider B alignment, same.
// - Monitor bit 2: synth_unlock_seen, held.
// - Wide layout adds bits 7,6 for D,C.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module synth_event_sticky_status (
   // Clock and reset.
   input wire logic mclk,
   input wire logic srst,

   // Phase-step completions, pll0.
   input wire logic pll0_out_a_step_done,
   input wire logic pll0_out_b_step_done,

   // Phase-step completions, pll1.
   input wire logic pll1_out_a_step_done,
   input wire logic pll1_out_b_step_done,
   input wire logic pll1_out_c_step_done,
   input wire logic pll1_out_d_step_done,

   // Phase-step completions, pll2.
   input wire logic pll2_out_a_step_done,
   input wire logic pll2_out_b_step_done,
   input wire logic pll2_out_c_step_done,
   input wire logic pll2_out_d_step_done,

   // Phase-step completions, pll3.
   input wire logic pll3_out_a_step_done,
   input wire logic pll3_out_b_step_done,

   // Synthesizer 0 monitor events.
   input wire logic pll0_out_a_align_done,
   input wire logic pll0_out_b_align_done,
   input wire logic pll0_out_c_align_done,
   input wire logic pll0_out_d_align_done,
   input wire logic synth_unlock_seen,

   // AXI4-Lite write address.
   input wire logic awvalid,
   output logic awready,
   input wire logic [11:0] awaddr,
   input wire logic [2:0] awprot,

   // AXI4-Lite write data.
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,

   // AXI4-Lite write response.
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,

   // AXI4-Lite read address.
   input wire logic arvalid,
   output logic arready,
   input wire logic [11:0] araddr,
   input wire logic [2:0] arprot,

   // AXI4-Lite read data.
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,

   // Interrupt.
   output logic irq
);

   typedef struct packed {
      logic [11:0] awAddr;
      logic awHeld;
      logic [7:0] wData;
      logic wLane0;
      logic wHeld;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [7:0] rData;
      logic [1:0] rResp;
      logic [7:0] maskLo;
      logic [7:0] maskHi;
      logic [7:0] maskMon;
      logic cfgWide;
   } ctrl_type;

   ctrl_type s_q;
   ctrl_type s_d;

   logic [7:0] stepLo;
   logic [7:0] stepHi;
   logic [7:0] mon0;
   logic [7:0] stepLoSet;
   logic [7:0] stepHiSet;
   logic [7:0] monSet;
   logic [7:0] stepLoClr;
   logic [7:0] stepHiClr;
   logic [7:0] monClr;
   logic [7:0] monValid;
   logic doWrite;
   logic [9:0] wrIdx;
   logic [9:0] rdIdx;

   // Word index of a byte address; the two low bits select nothing.
   function automatic logic [9:0] wordIndex(input logic [11:0] addr);
      return addr[11:2];
   endfunction

   // True when an index names a register of this bank.
   function automatic logic isMapped(input logic [9:0] idx);
      logic hit;
      hit = 1'b0;
      if (idx == synth_event_pkg::IDX_STEP_LO) begin
         hit = 1'b1;
      end else if (idx == synth_event_pkg::IDX_STEP_HI) begin
         hit = 1'b1;
      end else if (idx == synth_event_pkg::IDX_MON0) begin
         hit = 1'b1;
      end else if (idx == synth_event_pkg::IDX_MASK_LO) begin
         hit = 1'b1;
      end else if (idx == synth_event_pkg::IDX_MASK_HI) begin
         hit = 1'b1;
      end else if (idx == synth_event_pkg::IDX_MASK_MON) begin
         hit = 1'b1;
      end else if (idx == synth_event_pkg::IDX_CFG) begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   // Event placement in each status layout.
   assign stepLoSet = {
      pll1_out_d_step_done,
      pll1_out_c_step_done,
      pll1_out_b_step_done,
      pll1_out_a_step_done,
      2'h0,
      pll0_out_b_step_done,
      pll0_out_a_step_done
   };

   assign stepHiSet = {
      2'h0,
      pll3_out_b_step_done,
      pll3_out_a_step_done,
      pll2_out_d_step_done,
      pll2_out_c_step_done,
      pll2_out_b_step_done,
      pll2_out_a_step_done
   };

   assign monSet = {
      pll0_out_d_align_done,
      pll0_out_c_align_done,
      pll0_out_b_align_done,
      pll0_out_a_align_done,
      1'b0,
      synth_unlock_seen,
      2'h0
   };

   // Turning the wide layout off also drops any pending D and C alignment bits.
   assign monValid = s_q.cfgWide ? synth_event_pkg::MON_VALID_WIDE
                                 : synth_event_pkg::MON_VALID_NARROW;

   // The write happens in the first cycle in which both address and data are held.
   assign doWrite = s_q.awHeld && s_q.wHeld && !s_q.bValid;
   assign wrIdx = wordIndex(s_q.awAddr);
   assign rdIdx = wordIndex(araddr);

   // Acknowledge strobes: a one clears, a zero leaves the bit alone.
   always_comb begin
      stepLoClr = 8'h00;
      stepHiClr = 8'h00;
      monClr = 8'h00;
      if (doWrite && s_q.wLane0) begin
         if (wrIdx == synth_event_pkg::IDX_STEP_LO) begin
            stepLoClr = s_q.wData;
         end else if (wrIdx == synth_event_pkg::IDX_STEP_HI) begin
            stepHiClr = s_q.wData;
         end else if (wrIdx == synth_event_pkg::IDX_MON0) begin
            monClr = s_q.wData;
         end
      end
   end

   sticky_bank stepLoBank (
      .mclk(mclk),
      .srst(srst),
      .setEvents(stepLoSet),
      .clearBits(stepLoClr),
      .validBits(synth_event_pkg::STEP_LO_VALID),
      .status(stepLo)
   );

   sticky_bank stepHiBank (
      .mclk(mclk),
      .srst(srst),
      .setEvents(stepHiSet),
      .clearBits(stepHiClr),
      .validBits(synth_event_pkg::STEP_HI_VALID),
      .status(stepHi)
   );

   sticky_bank monBank (
      .mclk(mclk),
      .srst(srst),
      .setEvents(monSet),
      .clearBits(monClr),
      .validBits(monValid),
      .status(mon0)
   );

   // Bus and control state.
   always_comb begin
      s_d = s_q;

      // Address and data are taken independently, in either order.
      if (awvalid && awready) begin
         s_d.awAddr = awaddr;
         s_d.awHeld = 1'b1;
      end
      if (wvalid && wready) begin
         s_d.wData = wdata[7:0];
         s_d.wLane0 = wstrb[0];
         s_d.wHeld = 1'b1;
      end

      if (doWrite) begin
         s_d.awHeld = 1'b0;
         s_d.wHeld = 1'b0;
         s_d.bValid = 1'b1;
         s_d.bResp = isMapped(wrIdx) ? synth_event_pkg::RESP_OKAY
                                     : synth_event_pkg::RESP_SLVERR;
         if (s_q.wLane0) begin
            if (wrIdx == synth_event_pkg::IDX_MASK_LO) begin
               s_d.maskLo = s_q.wData & synth_event_pkg::STEP_LO_VALID;
            end else if (wrIdx == synth_event_pkg::IDX_MASK_HI) begin
               s_d.maskHi = s_q.wData & synth_event_pkg::STEP_HI_VALID;
            end else if (wrIdx == synth_event_pkg::IDX_MASK_MON) begin
               s_d.maskMon = s_q.wData & synth_event_pkg::MON_VALID_WIDE;
            end else if (wrIdx == synth_event_pkg::IDX_CFG) begin
               s_d.cfgWide = s_q.wData[synth_event_pkg::CFG_WIDE_BIT];
            end
         end
      end else if (s_q.bValid && bready) begin
         s_d.bValid = 1'b0;
      end

      // One read at a time; the data are captured when the address is taken.
      if (arvalid && arready) begin
         s_d.rValid = 1'b1;
         s_d.rResp = synth_event_pkg::RESP_OKAY;
         if (rdIdx == synth_event_pkg::IDX_STEP_LO) begin
            s_d.rData = stepLo;
         end else if (rdIdx == synth_event_pkg::IDX_STEP_HI) begin
            s_d.rData = stepHi;
         end else if (rdIdx == synth_event_pkg::IDX_MON0) begin
            s_d.rData = mon0;
         end else if (rdIdx == synth_event_pkg::IDX_MASK_LO) begin
            s_d.rData = s_q.maskLo;
         end else if (rdIdx == synth_event_pkg::IDX_MASK_HI) begin
            s_d.rData = s_q.maskHi;
         end else if (rdIdx == synth_event_pkg::IDX_MASK_MON) begin
            s_d.rData = s_q.maskMon;
         end else if (rdIdx == synth_event_pkg::IDX_CFG) begin
            s_d.rData = {7'h00, s_q.cfgWide};
         end else begin
            s_d.rData = 8'h00;
            s_d.rResp = synth_event_pkg::RESP_SLVERR;
         end
      end else if (s_q.rValid && rready) begin
         s_d.rValid = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s_q.awAddr <= 12'h000;
         s_q.awHeld <= 1'b0;
         s_q.wData <= 8'h00;
         s_q.wLane0 <= 1'b0;
         s_q.wHeld <= 1'b0;
         s_q.bValid <= 1'b0;
         s_q.bResp <= synth_event_pkg::RESP_OKAY;
         s_q.rValid <= 1'b0;
         s_q.rData <= 8'h00;
         s_q.rResp <= synth_event_pkg::RESP_OKAY;
         s_q.maskLo <= synth_event_pkg::MASK_RESET;
         s_q.maskHi <= synth_event_pkg::MASK_RESET;
         s_q.maskMon <= synth_event_pkg::MASK_RESET;
         s_q.cfgWide <= synth_event_pkg::CFG_WIDE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // Ready only while the slot is empty and no response is pending.
   assign awready = !s_q.awHeld && !s_q.bValid;
   assign wready = !s_q.wHeld && !s_q.bValid;
   assign arready = !s_q.rValid;

   assign bvalid = s_q.bValid;
   assign bresp = s_q.bResp;
   assign rvalid = s_q.rValid;
   assign rdata = {24'h000000, s_q.rData};
   assign rresp = s_q.rResp;

   // The level follows the sticky bits directly, so it drops in the cycle after the clear.
   assign irq = |(stepLo & s_q.maskLo) | |(stepHi & s_q.maskHi) | |(mon0 & s_q.maskMon);

endmodule

//--- tb/synth_event_sticky_status_chk.sv
// Purpose: Read-side checks of the synthesizer sticky status bank.
// Assumes: Sees only top-level ports; event checks need a read within two cycles.
// Notes: The window is short because a clear in between would hide the bit.
`timescale 1ns/1ps
module synth_event_sticky_status_chk (
   // Clock and reset.
   input wire logic mclk,
   input wire logic srst,
   // Events.
   input wire logic pll1_out_d_step_done,
   input wire logic pll2_out_c_step_done,
   input wire logic pll0_out_a_align_done,
   input wire logic pll0_out_b_align_done,
   input wire logic synth_unlock_seen,
   // Read channel.
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [11:0] araddr,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   // Interrupt.
   input wire logic irq
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (srst);
   sequence rd_at(logic [9:0] idx);
      arvalid && arready && araddr[11:2] == idx;
   endsequence
   a_pll1_d_set: assert property (
      pll1_out_d_step_done ##[1:2] rd_at(synth_event_pkg::IDX_STEP_LO) |=> rdata[7])
      else $error("Step bit lost.");
   a_lo_reserved: assert property (
      rd_at(synth_event_pkg::IDX_STEP_LO) |=> rdata[3:2] == 2'h0)
      else $error("Reserved low bits set.");
   a_hi_reserved: assert property (
      rd_at(synth_event_pkg::IDX_STEP_HI) |=> rdata[7:6] == 2'h0)
      else $error("Reserved high bits set.");
   a_pll2_c_set: assert property (
      pll2_out_c_step_done ##[1:2] rd_at(synth_event_pkg::IDX_STEP_HI) |=> rdata[2])
      else $error("Step bit lost.");
   a_align_a_set: assert property (
      pll0_out_a_align_done ##[1:2] rd_at(synth_event_pkg::IDX_MON0) |=> rdata[4])
      else $error("Align bit lost.");
   a_align_b_set: assert property (
      pll0_out_b_align_done ##[1:2] rd_at(synth_event_pkg::IDX_MON0) |=> rdata[5])
      else $error("Align bit lost.");
   a_unlock_set: assert property (
      synth_unlock_seen ##[1:2] rd_at(synth_event_pkg::IDX_MON0) |=> rdata[2] && !rdata[3])
      else $error("Unlock bit wrong.");
   a_read_hold: assert property (
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("Read answer dropped.");
   c_irq: cover property ($rose(irq));
   c_slverr: cover property (rvalid && rresp == synth_event_pkg::RESP_SLVERR);
   c_stall: cover property (rvalid && !rready);
endmodule

bind synth_event_sticky_status synth_event_sticky_status_chk i_synth_event_sticky_status_chk (
   .mclk(mclk),
   .srst(srst),
   .pll1_out_d_step_done(pll1_out_d_step_done),
   .pll2_out_c_step_done(pll2_out_c_step_done),
   .pll0_out_a_align_done(pll0_out_a_align_done),
   .pll0_out_b_align_done(pll0_out_b_align_done),
   .synth_unlock_seen(synth_unlock_seen),
   .arvalid(arvalid),
   .arready(arready),
   .araddr(araddr),
   .rvalid(rvalid),
   .rready(rready),
   .rdata(rdata),
   .rresp(rresp),
   .irq(irq)
);

//--- tb/testbench.sv
// Purpose: Register-level test of the synthesizer sticky status bank.
// Assumes: One AXI4-Lite transfer at a time.
// Notes: Every wait is bounded; running out counts as a mismatch.
`timescale 1ns/1ps
module testbench;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic [2:0] awprot = 3'h0;
   logic [2:0] arprot = 3'h0;
   logic [16:0] ev = 17'h0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int err_count = 0;
   int n_tests = 0;
   int bitPos [17] = '{0, 1, 4, 5, 6, 7, 0, 1, 2, 3, 4, 5, 4, 5, 6, 7, 2};
   always #50 mclk = ~mclk;
   synth_event_sticky_status i_synth_event_sticky_status (
      .mclk(mclk), .srst(srst),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .irq(irq),
      .pll0_out_a_step_done(ev[0]), .pll0_out_b_step_done(ev[1]),
      .pll1_out_a_step_done(ev[2]), .pll1_out_b_step_done(ev[3]),
      .pll1_out_c_step_done(ev[4]), .pll1_out_d_step_done(ev[5]),
      .pll2_out_a_step_done(ev[6]), .pll2_out_b_step_done(ev[7]),
      .pll2_out_c_step_done(ev[8]), .pll2_out_d_step_done(ev[9]),
      .pll3_out_a_step_done(ev[10]), .pll3_out_b_step_done(ev[11]),
      .pll0_out_a_align_done(ev[12]), .pll0_out_b_align_done(ev[13]),
      .pll0_out_c_align_done(ev[14]), .pll0_out_d_align_done(ev[15]),
      .synth_unlock_seen(ev[16]));
   function automatic logic [9:0] regOf(input int i);
      return i < 6 ? synth_event_pkg::IDX_STEP_LO :
         i < 12 ? synth_event_pkg::IDX_STEP_HI : synth_event_pkg::IDX_MON0;
   endfunction
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tmo(input int n);
      if (n >= 50) begin
         err_count++;
         $display("[FAIL] bus wait expected below 50 seen %0d", n);
         final_report();
      end
   endtask
   task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
      int n;
      logic ta;
      logic tw;
      n = 0;
      ta = 1'b0;
      tw = 1'b0;
      awaddr <= {idx, 2'h0};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ta && tw) && n < 50) begin
         @(negedge mclk);
         ta = ta | awready;
         tw = tw | wready;
         @(posedge mclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         n++;
      end
      do begin
         @(negedge mclk);
         n++;
      end while (!bvalid && n < 50);
      chk("bresp", {30'h0, bresp}, {30'h0, er});
      @(posedge mclk);
      bready <= 1'b0;
      tmo(n);
      @(posedge mclk);
   endtask
   // The ready is raised late on purpose, so the held answer is exercised.
   task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
      int n;
      n = 0;
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      do begin
         @(negedge mclk);
         n++;
      end while (!arready && n < 50);
      @(posedge mclk);
      arvalid <= 1'b0;
      do begin
         @(negedge mclk);
         n++;
      end while (!rvalid && n < 50);
      @(posedge mclk);
      rready <= 1'b1;
      @(negedge mclk);
      chk("rdata", rdata, exp);
      chk("rresp", {30'h0, rresp}, {30'h0, er});
      @(posedge mclk);
      rready <= 1'b0;
      tmo(n);
      @(posedge mclk);
   endtask
   task automatic pulse(input int i);
      ev[i] <= 1'b1;
      @(posedge mclk);
      ev[i] <= 1'b0;
      @(posedge mclk);
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      rd(synth_event_pkg::IDX_STEP_LO, 32'h0, 2'h0);
      rd(synth_event_pkg::IDX_STEP_HI, 32'h0, 2'h0);
      rd(synth_event_pkg::IDX_MON0, 32'h0, 2'h0);
      rd(synth_event_pkg::IDX_CFG, 32'h0, 2'h0);
      rd(10'h1ae, 32'h0, synth_event_pkg::RESP_SLVERR);
      $display("Test reset values done");
      pulse(14);
      pulse(15);
      rd(synth_event_pkg::IDX_MON0, 32'h0, 2'h0);
      wr(synth_event_pkg::IDX_CFG, 8'h01, 2'h0);
      rd(synth_event_pkg::IDX_CFG, 32'h1, 2'h0);
      for (int i = 0; i < 17; i++) begin
         pulse(i);
         rd(regOf(i), 32'h1 << bitPos[i], 2'h0);
         wr(regOf(i), 8'h1 << bitPos[i], 2'h0);
         rd(regOf(i), 32'h0, 2'h0);
      end
      $display("Test event bits done");
      ev <= 17'h1ffff;
      repeat (2) @(posedge mclk);
      ev <= 17'h00100;
      rd(synth_event_pkg::IDX_STEP_LO, 32'hf3, 2'h0);
      rd(synth_event_pkg::IDX_STEP_HI, 32'h3f, 2'h0);
      rd(synth_event_pkg::IDX_MON0, 32'hf4, 2'h0);
      wr(synth_event_pkg::IDX_STEP_LO, 8'h00, 2'h0);
      rd(synth_event_pkg::IDX_STEP_LO, 32'hf3, 2'h0);
      wr(synth_event_pkg::IDX_STEP_HI, 8'hff, 2'h0);
      rd(synth_event_pkg::IDX_STEP_HI, 32'h04, 2'h0);
      ev <= 17'h0;
      wr(10'h1ae, 8'hff, synth_event_pkg::RESP_SLVERR);
      $display("Test reserved and clear done");
      #1;
      chk("irq", {31'h0, irq}, 32'h0);
      wr(synth_event_pkg::IDX_MASK_HI, 8'h04, 2'h0);
      #1;
      chk("irq", {31'h0, irq}, 32'h1);
      wr(synth_event_pkg::IDX_STEP_HI, 8'h04, 2'h0);
      #1;
      chk("irq", {31'h0, irq}, 32'h0);
      wr(synth_event_pkg::IDX_STEP_LO, 8'hff, 2'h0);
      wr(synth_event_pkg::IDX_MON0, 8'hff, 2'h0);
      wr(synth_event_pkg::IDX_MASK_LO, 8'hff, 2'h0);
      rd(synth_event_pkg::IDX_MASK_LO, 32'hf3, 2'h0);
      wr(synth_event_pkg::IDX_MASK_MON, 8'hff, 2'h0);
      rd(synth_event_pkg::IDX_MASK_MON, 32'hf4, 2'h0);
      #1;
      chk("irq", {31'h0, irq}, 32'h0);
      pulse(16);
      #1;
      chk("irq", {31'h0, irq}, 32'h1);
      wr(synth_event_pkg::IDX_MON0, 8'h04, 2'h0);
      #1;
      chk("irq", {31'h0, irq}, 32'h0);
      pulse(0);
      wstrb <= 4'h0;
      wr(synth_event_pkg::IDX_STEP_LO, 8'h01, 2'h0);
      rd(synth_event_pkg::IDX_STEP_LO, 32'h01, 2'h0);
      wstrb <= 4'hf;
      #1;
      chk("irq", {31'h0, irq}, 32'h1);
      wr(synth_event_pkg::IDX_STEP_LO, 8'h01, 2'h0);
      #1;
      chk("irq", {31'h0, irq}, 32'h0);
      $display("Test interrupt done");
      final_report();
   end
endmodule
